// >>> core/eldr_consts.svh
// Constants of the electrode disconnect register bank
// What this block does
// - One pull reverse bit per channel; bit 7 is channel 8, bit 0 channel 1
// - Pull reverse bits are read/write and reset to zero, meaning unreversed pull
// - Positive disconnect status is read-only at index 12h, resets to 00h
// - Negative disconnect status is read-only at index 13h, resets to 00h
// - A status bit reads 1 while its electrode is off, 0 while on
// - Detect enables live at index 0Fh (positive) and 10h (negative)
`ifndef ELDR_CONSTS_SVH
`define ELDR_CONSTS_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define ELDR_IDX_POS_EN     8'h0f
`define ELDR_IDX_NEG_EN     8'h10
`define ELDR_IDX_POLARITY   8'h11
`define ELDR_IDX_POS_STAT   8'h12
`define ELDR_IDX_NEG_STAT   8'h13
`define ELDR_IDX_IRQ_STAT   8'h18
`define ELDR_IDX_IRQ_MASK   8'h19

// ==========================================================
// Reset values
`define ELDR_RST_POS_EN     8'h00
`define ELDR_RST_NEG_EN     8'h00
`define ELDR_RST_POLARITY   8'h00
`define ELDR_RST_STAT       8'h00
`define ELDR_RST_IRQ        16'h0000

// ==========================================================
// Field positions
`define ELDR_WORD_LSB       2
`define ELDR_IRQ_POS_LSB    0
`define ELDR_IRQ_NEG_LSB    8

`endif

// >>> core/eldr_pkg.sv
// Types of the electrode disconnect register bank
package eldr_pkg;

  typedef logic [7:0] eldr_chan_t;

  typedef enum logic [1:0] {
    ELDR_APB_IDLE   = 2'b00,
    ELDR_APB_ACCESS = 2'b01
  } eldr_apb_state_t;

endpackage : eldr_pkg

// >>> core/eldr_sync.sv
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
module eldr_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstSync_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  // ==========================================================
  // Per-bit stages
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : gBit
      logic stage1;
      logic next_stage1;
      logic next_stage2;
      always_comb begin
        next_stage1 = asyncIn[gi];
        next_stage2 = stage1;
      end
      always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
          stage1      <= 1'b0;
          syncOut[gi] <= 1'b0;
        end else begin
          stage1      <= next_stage1;
          syncOut[gi] <= next_stage2;
        end
      end
    end
  endgenerate

endmodule : eldr_sync

// >>> core/eldr_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ns
`include "eldr_consts.svh"
module eldr_irq #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rstSync_n,
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic             statClear,
  input  wire logic             maskWrite,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] status,
  output logic      [WIDTH-1:0] mask,
  output logic                  irq
);

  logic [WIDTH-1:0] next_status;
  logic [WIDTH-1:0] next_mask;
  logic             next_irq;

  // ==========================================================
  // Write one to clear, a new event wins over the clear
  always_comb begin
    next_status = status;
    if (statClear) begin
      next_status = next_status & ~wdata;
    end
    next_status = next_status | event_in;
    next_mask   = maskWrite ? wdata : mask;
    next_irq    = |(next_status & next_mask);
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      status <= `ELDR_RST_IRQ;
      mask   <= `ELDR_RST_IRQ;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= next_irq;
    end
  end

endmodule : eldr_irq

// >>> core/eldr_regs.sv
// Electrode disconnect register bank with APB slave
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`include "eldr_consts.svh"
module eldr_regs #(
  parameter int ADDR_W = 12,
  parameter int NCH    = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Detector comparators, asynchronous
  input  wire logic [NCH-1:0]    posElectrodeOffRaw,
  input  wire logic [NCH-1:0]    negElectrodeOffRaw,
  // Analog controls and interrupt
  output logic      [NCH-1:0]    pullReverse,
  output logic      [NCH-1:0]    posDetectEnable,
  output logic      [NCH-1:0]    negDetectEnable,
  output logic                   irq
);

  // ==========================================================
  // Reset release
  logic rstMeta_n;
  logic rstSync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ==========================================================
  // Detector synchronisers
  logic [NCH-1:0] posOffSync;
  logic [NCH-1:0] negOffSync;

  eldr_sync #(
    .WIDTH (NCH)
  ) uPosSync (
    .sys_clk   (sys_clk),
    .rstSync_n (rstSync_n),
    .asyncIn   (posElectrodeOffRaw),
    .syncOut   (posOffSync)
  );

  eldr_sync #(
    .WIDTH (NCH)
  ) uNegSync (
    .sys_clk   (sys_clk),
    .rstSync_n (rstSync_n),
    .asyncIn   (negElectrodeOffRaw),
    .syncOut   (negOffSync)
  );

  // ==========================================================
  // Register state
  logic [NCH-1:0] positive_detect_enable;
  logic [NCH-1:0] negative_detect_enable;
  logic [NCH-1:0] disconnect_pull_polarity;
  logic [NCH-1:0] positive_electrode_off_status;
  logic [NCH-1:0] negative_electrode_off_status;

  logic [NCH-1:0] next_positive_detect_enable;
  logic [NCH-1:0] next_negative_detect_enable;
  logic [NCH-1:0] next_disconnect_pull_polarity;
  logic [NCH-1:0] next_positive_electrode_off_status;
  logic [NCH-1:0] next_negative_electrode_off_status;

  // ==========================================================
  // APB decode
  eldr_pkg::eldr_apb_state_t apbState;
  eldr_pkg::eldr_apb_state_t next_apbState;
  logic [31:0]               next_prdata;
  logic                      next_pready;
  logic                      next_pslverr;
  logic [7:0]                wordIdx;
  logic                      setupPhase;
  logic                      writeCommit;
  logic                      hitPosEn;
  logic                      hitNegEn;
  logic                      hitPolarity;
  logic                      hitPosStat;
  logic                      hitNegStat;
  logic                      hitIrqStat;
  logic                      hitIrqMask;
  logic                      hitAny;
  logic                      idxInRange;
  logic [31:0]               readWord;

  logic [2*NCH-1:0]          irqStatus;
  logic [2*NCH-1:0]          irqMask;
  logic [2*NCH-1:0]          irqEvent;
  logic                      irqClear;
  logic                      irqMaskWrite;
  logic                      next_irq;
  logic                      irqLevel;

  always_comb begin
    // Indices past eight bits never alias onto a register
    idxInRange  = ((paddr >> `ELDR_WORD_LSB) >> 8) == '0;
    wordIdx     = idxInRange ? 8'(paddr >> `ELDR_WORD_LSB) : 8'hff;
    setupPhase  = psel && !penable;
    writeCommit = psel && penable && pready && pwrite;
    hitPosEn    = (wordIdx == `ELDR_IDX_POS_EN);
    hitNegEn    = (wordIdx == `ELDR_IDX_NEG_EN);
    hitPolarity = (wordIdx == `ELDR_IDX_POLARITY);
    hitPosStat  = (wordIdx == `ELDR_IDX_POS_STAT);
    hitNegStat  = (wordIdx == `ELDR_IDX_NEG_STAT);
    hitIrqStat  = (wordIdx == `ELDR_IDX_IRQ_STAT);
    hitIrqMask  = (wordIdx == `ELDR_IDX_IRQ_MASK);
    hitAny      = hitPosEn || hitNegEn || hitPolarity || hitPosStat ||
                  hitNegStat || hitIrqStat || hitIrqMask;
  end

  // ==========================================================
  // Read data selection, unmapped indices read zero
  always_comb begin
    readWord = 32'h0000_0000;
    case (wordIdx)
      `ELDR_IDX_POS_EN: begin
        readWord = {{(32-NCH){1'b0}}, positive_detect_enable};
      end
      `ELDR_IDX_NEG_EN: begin
        readWord = {{(32-NCH){1'b0}}, negative_detect_enable};
      end
      `ELDR_IDX_POLARITY: begin
        readWord = {{(32-NCH){1'b0}}, disconnect_pull_polarity};
      end
      `ELDR_IDX_POS_STAT: begin
        readWord = {{(32-NCH){1'b0}}, positive_electrode_off_status};
      end
      `ELDR_IDX_NEG_STAT: begin
        readWord = {{(32-NCH){1'b0}}, negative_electrode_off_status};
      end
      `ELDR_IDX_IRQ_STAT: begin
        readWord = {{(32-2*NCH){1'b0}}, irqStatus};
      end
      `ELDR_IDX_IRQ_MASK: begin
        readWord = {{(32-2*NCH){1'b0}}, irqMask};
      end
      default: begin
        readWord = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // APB handshake, answer in first access cycle
  always_comb begin
    next_apbState = apbState;
    next_pready   = 1'b0;
    next_pslverr  = 1'b0;
    next_prdata   = 32'h0000_0000;
    case (apbState)
      eldr_pkg::ELDR_APB_IDLE: begin
        if (setupPhase) begin
          next_apbState = eldr_pkg::ELDR_APB_ACCESS;
          next_pready   = 1'b1;
          next_pslverr  = !hitAny;
          if (!pwrite) begin
            next_prdata = readWord;
          end
        end
      end
      eldr_pkg::ELDR_APB_ACCESS: begin
        next_apbState = eldr_pkg::ELDR_APB_IDLE;
      end
      default: begin
        next_apbState = eldr_pkg::ELDR_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      apbState <= eldr_pkg::ELDR_APB_IDLE;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
    end else begin
      apbState <= next_apbState;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      prdata   <= next_prdata;
    end
  end

  // ==========================================================
  // Control and status registers
  always_comb begin
    next_positive_detect_enable   = positive_detect_enable;
    next_negative_detect_enable   = negative_detect_enable;
    next_disconnect_pull_polarity = disconnect_pull_polarity;
    if (writeCommit && hitPosEn) begin
      next_positive_detect_enable = pwdata[NCH-1:0];
    end
    if (writeCommit && hitNegEn) begin
      next_negative_detect_enable = pwdata[NCH-1:0];
    end
    if (writeCommit && hitPolarity) begin
      next_disconnect_pull_polarity = pwdata[NCH-1:0];
    end
    next_positive_electrode_off_status = posOffSync;
    next_negative_electrode_off_status = negOffSync;
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      positive_detect_enable        <= `ELDR_RST_POS_EN;
      negative_detect_enable        <= `ELDR_RST_NEG_EN;
      disconnect_pull_polarity      <= `ELDR_RST_POLARITY;
      positive_electrode_off_status <= `ELDR_RST_STAT;
      negative_electrode_off_status <= `ELDR_RST_STAT;
    end else begin
      positive_detect_enable        <= next_positive_detect_enable;
      negative_detect_enable        <= next_negative_detect_enable;
      disconnect_pull_polarity      <= next_disconnect_pull_polarity;
      positive_electrode_off_status <= next_positive_electrode_off_status;
      negative_electrode_off_status <= next_negative_electrode_off_status;
    end
  end

  // ==========================================================
  // Analog control outputs
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pullReverse     <= `ELDR_RST_POLARITY;
      posDetectEnable <= `ELDR_RST_POS_EN;
      negDetectEnable <= `ELDR_RST_NEG_EN;
    end else begin
      pullReverse     <= next_disconnect_pull_polarity;
      posDetectEnable <= next_positive_detect_enable;
      negDetectEnable <= next_negative_detect_enable;
    end
  end

  // ==========================================================
  // Per-channel rising edge of each disconnect status bit
  logic [NCH-1:0] posOffRise;
  logic [NCH-1:0] negOffRise;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : gChan
      assign posOffRise[ch] = next_positive_electrode_off_status[ch] &&
                              !positive_electrode_off_status[ch];
      assign negOffRise[ch] = next_negative_electrode_off_status[ch] &&
                              !negative_electrode_off_status[ch];
    end
  endgenerate

  // ==========================================================
  // Disconnect events, only on enabled inputs
  always_comb begin
    irqEvent = '0;
    irqEvent[`ELDR_IRQ_POS_LSB +: NCH] = posOffRise & positive_detect_enable;
    irqEvent[`ELDR_IRQ_NEG_LSB +: NCH] = negOffRise & negative_detect_enable;
    irqClear     = writeCommit && hitIrqStat;
    irqMaskWrite = writeCommit && hitIrqMask;
    next_irq     = irqLevel;
  end

  // ==========================================================
  // Sticky interrupt status and mask
  eldr_irq #(
    .WIDTH (2*NCH)
  ) uIrq (
    .sys_clk   (sys_clk),
    .rstSync_n (rstSync_n),
    .event_in  (irqEvent),
    .statClear (irqClear),
    .maskWrite (irqMaskWrite),
    .wdata     (pwdata[2*NCH-1:0]),
    .status    (irqStatus),
    .mask      (irqMask),
    .irq       (irqLevel)
  );

  // ==========================================================
  // Interrupt output flop
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule : eldr_regs

// >>> sim/eldr_regs_asserts.sv
// Port checker for the electrode disconnect register bank
`timescale 1ns/1ns
module eldr_regs_asserts #(
  parameter int ADDR_W = 12,
  parameter int NCH    = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NCH-1:0]    posElectrodeOffRaw,
  input wire logic [NCH-1:0]    negElectrodeOffRaw,
  input wire logic [NCH-1:0]    pullReverse,
  input wire logic [NCH-1:0]    posDetectEnable,
  input wire logic [NCH-1:0]    negDetectEnable,
  input wire logic              irq
);
  // ==========================================================
  // Cycles since detector inputs last changed
  logic [3:0]       stab;
  logic [3:0]       next_stab;
  logic [2*NCH-1:0] prevRaw;
  always_comb begin
    next_stab = ({posElectrodeOffRaw, negElectrodeOffRaw} != prevRaw) ? 4'h0 : stab + {3'h0, stab != 4'hf};
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stab    <= 4'h0;
      prevRaw <= '0;
    end else begin
      stab    <= next_stab;
      prevRaw <= {posElectrodeOffRaw, negElectrodeOffRaw};
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> pready ##1 !pready;
  endproperty
  property p_unmapped;
    s_acc ##0 paddr == 12'h050 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_polRead;
    s_acc ##0 (!pwrite && paddr == 12'h044) |-> !pslverr && prdata == {{(32-NCH){1'b0}}, pullReverse};
  endproperty
  property p_polWrite;
    s_acc ##0 (pwrite && paddr == 12'h044) |=> pullReverse == $past(pwdata[NCH-1:0]);
  endproperty
  property p_polHold;
    !(psel && penable && pready && pwrite && paddr == 12'h044) |=> $stable(pullReverse);
  endproperty
  property p_posEn;
    s_acc ##0 (pwrite && paddr == 12'h03c) |=> posDetectEnable == $past(pwdata[NCH-1:0]);
  endproperty
  property p_negEn;
    s_acc ##0 (pwrite && paddr == 12'h040) |=> negDetectEnable == $past(pwdata[NCH-1:0]);
  endproperty
  property p_posStat;
    s_acc ##0 (!pwrite && paddr == 12'h048 && stab > 4'h5) |-> prdata == {{(32-NCH){1'b0}}, posElectrodeOffRaw};
  endproperty
  property p_negStat;
    s_acc ##0 (!pwrite && paddr == 12'h04c && stab > 4'h5) |-> prdata == {{(32-NCH){1'b0}}, negElectrodeOffRaw};
  endproperty
  a_answer: assert property (p_answer) else $error("pready not one cycle after setup");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_polRead: assert property (p_polRead) else $error("polarity read mismatch");
  a_polWrite: assert property (p_polWrite) else $error("polarity write lost");
  a_polHold: assert property (p_polHold) else $error("polarity changed without write");
  a_posEn: assert property (p_posEn) else $error("positive enable write lost");
  a_negEn: assert property (p_negEn) else $error("negative enable write lost");
  a_posStat: assert property (p_posStat) else $error("positive status mismatch");
  a_negStat: assert property (p_negStat) else $error("negative status mismatch");
endmodule : eldr_regs_asserts

bind eldr_regs eldr_regs_asserts #(.ADDR_W(ADDR_W), .NCH(NCH)) u_asserts (.sys_clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .posElectrodeOffRaw, .negElectrodeOffRaw, .pullReverse,
  .posDetectEnable, .negDetectEnable, .irq);

// >>> sim/electrode_disconnect_regs_tb.sv
// Testbench of the electrode disconnect register bank
`timescale 1ns/1ns
module electrode_disconnect_regs_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  posElectrodeOffRaw = 8'h0;
  logic [7:0]  negElectrodeOffRaw = 8'h0;
  logic [7:0]  pullReverse;
  logic [7:0]  posDetectEnable;
  logic [7:0]  negDetectEnable;
  logic        irq;
  logic [31:0] rdat;
  int          numErrors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #50 sys_clk = ~sys_clk;

  eldr_regs #(.ADDR_W(12), .NCH(8)) uut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .posElectrodeOffRaw, .negElectrodeOffRaw, .pullReverse, .posDetectEnable,
    .negDetectEnable, .irq);

  // ==========================================================
  // Tasks
  task automatic completeRun();
    if (numErrors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : completeRun

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      numErrors++;
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    chk("pslverr", {31'h0, a == 12'h050 || a[11:10] != 2'b00}, {31'h0, pslverr});
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask : rc

  task automatic gap(input int n);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : gap

  // ==========================================================
  // Timeout
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      numErrors++;
      completeRun();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("pullReverse", 32'h0, {24'h0, pullReverse});
    rc(12'h03c, 32'h0);
    rc(12'h040, 32'h0);
    rc(12'h044, 32'h0);
    rc(12'h048, 32'h0);
    rc(12'h04c, 32'h0);
    rc(12'h060, 32'h0);
    rc(12'h064, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(12'h044, 32'hffff_ff00 | (32'h1 << i));
      rc(12'h044, 32'h1 << i);
      chk("pullReverse", 32'h1 << i, {24'h0, pullReverse});
    end
    wr(12'h044, 32'h0);
    rc(12'h044, 32'h0);
    wr(12'h03c, 32'h81);
    wr(12'h040, 32'h42);
    rc(12'h03c, 32'h81);
    rc(12'h040, 32'h42);
    chk("posDetectEnable", 32'h81, {24'h0, posDetectEnable});
    chk("negDetectEnable", 32'h42, {24'h0, negDetectEnable});
    wr(12'h050, 32'hff);
    rc(12'h050, 32'h0);
    wr(12'h43c, 32'h00);
    rc(12'h43c, 32'h0);
    rc(12'h03c, 32'h81);
    posElectrodeOffRaw <= 8'h5a;
    negElectrodeOffRaw <= 8'hc3;
    gap(8);
    rc(12'h048, 32'h5a);
    chk("posStatEnabled", 32'h00, rdat & 32'h81);
    rc(12'h04c, 32'hc3);
    chk("negStatEnabled", 32'h42, rdat & 32'h42);
    wr(12'h048, 32'hff);
    wr(12'h04c, 32'h00);
    rc(12'h048, 32'h5a);
    rc(12'h04c, 32'hc3);
    posElectrodeOffRaw <= 8'h00;
    negElectrodeOffRaw <= 8'h00;
    gap(8);
    rc(12'h048, 32'h0);
    rc(12'h04c, 32'h0);
    rc(12'h060, 32'h4200);
    wr(12'h060, 32'hffff);
    rc(12'h060, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(12'h064, 32'h0001);
    rc(12'h064, 32'h0001);
    posElectrodeOffRaw <= 8'h05;
    negElectrodeOffRaw <= 8'h02;
    gap(8);
    chk("irq", 32'h1, {31'h0, irq});
    rc(12'h060, 32'h0201);
    wr(12'h060, 32'h0001);
    rc(12'h060, 32'h0200);
    gap(3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(12'h064, 32'h0200);
    gap(3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h060, 32'h0200);
    gap(3);
    chk("irq", 32'h0, {31'h0, irq});
    rc(12'h060, 32'h0);
    rc(12'h048, 32'h05);
    gap(1);
    completeRun();
  end
endmodule : electrode_disconnect_regs_tb
